// ===== hw/svr_top.sv
// Voice router, arming controller, LED driver and compliance monitor with APB registers.
// Assumes all inputs synchronous to clk_sys and an APB master that holds each request.
`timescale 1ns/1ps

module svr_top #(
  parameter int unsigned NUM_SUB    = 2,
  parameter int unsigned NUM_BOARDS = 4,
  parameter int unsigned NV_IN      = 8
) (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Stimulus source and arming inputs
  input  wire logic [NUM_SUB-1:0][2*NV_IN-1:0][svr_pkg::DW-1:0] stim_voice_input,
  input  wire logic                         link_up,
  input  wire logic                         touch_arm,
  input  wire logic [svr_pkg::DW-1:0]       current_sense,
  input  wire logic [NUM_BOARDS-1:0][3:0][svr_pkg::DW-1:0] compliance_mv,
  // Board outputs
  output svr_pkg::svr_voice_t [NUM_BOARDS-1:0][3:0] voice_out,
  output logic [NUM_BOARDS-1:0][15:0]       led_red,
  output logic [NUM_BOARDS-1:0][15:0]       led_green,
  output logic [NUM_BOARDS-1:0][1:0]        ground_sel,
  // Compliance monitor stream
  output logic [svr_pkg::DW-1:0]            compliance_monitor_out,
  output logic [7:0]                        mon_index,
  output logic                              mon_valid,
  output logic                              mon_store,
  // State and interrupt
  output svr_pkg::svr_arm_t                 arm_state,
  output logic                              irq
);

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    svr_pkg::svr_arm_t                          arm;
    logic [31:0]                                prdata;
    logic                                       pready;
    logic                                       pslverr;
    logic [31:0]                                safe;
    logic [15:0]                                ilim;
    logic [svr_pkg::IRQ_W-1:0]                  irq_stat;
    logic [svr_pkg::IRQ_W-1:0]                  irq_mask;
    logic                                       irq;
    svr_pkg::svr_sub_cfg_t [NUM_SUB-1:0]        cfg;
    svr_pkg::svr_voice_t [NUM_BOARDS-1:0][3:0]  vout;
    logic [NUM_BOARDS-1:0][15:0]                red;
    logic [NUM_BOARDS-1:0][15:0]                green;
    logic [NUM_BOARDS-1:0][1:0]                 gnd;
    logic [svr_pkg::DW-1:0]                     mon;
    logic [7:0]                                 mon_ptr;
    logic [7:0]                                 mon_idx;
    logic                                       mon_valid;
    logic                                       mon_store;
  } svr_state_t;

  svr_state_t st;
  svr_state_t next_st;

  logic                        acc;
  logic                        wr_commit;
  logic                        rd_hit;
  logic [31:0]                 rdata;
  logic                        host_arm;
  logic                        host_disarm;
  logic                        arm_req;
  logic                        safe_en;
  logic                        remote;
  logic                        zero_cur;
  logic                        link_ok;
  logic                        v_fault;
  logic                        i_fault;
  logic                        gate;
  logic [16:0]                 vlim;
  logic [svr_pkg::IRQ_W-1:0]   set_irq;
  logic [svr_pkg::IRQ_W-1:0]   clr_irq;
  logic                        used;
  logic                        ok;
  logic                        in_rng;
  logic [2:0]                  shift;
  logic [3:0]                  ch;
  logic [svr_pkg::DW-1:0]      amp;
  logic [NUM_BOARDS-1:0][1:0]  bmon;
  svr_pkg::svr_sub_cfg_t       c;
  int                          first_b;
  int                          sb;
  int                          k;
  int                          gi;
  int                          vi;
  int                          t;
  int                          base;

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st     = st;
    acc         = psel & penable;
    wr_commit   = acc & pwrite & st.pready;
    host_arm    = wr_commit & (paddr == svr_pkg::ADDR_CTRL) & pwdata[svr_pkg::CTRL_ARM_BIT];
    host_disarm = wr_commit & (paddr == svr_pkg::ADDR_CTRL) & pwdata[svr_pkg::CTRL_DISARM_BIT];
    safe_en     = st.safe[svr_pkg::SAFE_EN_BIT];
    remote      = st.safe[svr_pkg::SAFE_REMOTE_BIT];
    vlim        = {1'b0, st.safe[svr_pkg::SAFE_VMAX_LSB +: 16]} + {1'b0, svr_pkg::VOLT_MARGIN_MV};
    rdata       = 32'h0000_0000;
    rd_hit      = 1'b1;
    set_irq     = '0;
    clr_irq     = '0;
    zero_cur    = 1'b1;
    v_fault     = 1'b0;
    used        = 1'b0;
    ok          = 1'b0;
    in_rng      = 1'b0;
    shift       = 3'd0;
    ch          = 4'h0;
    amp         = '0;
    bmon        = '0;
    c           = st.cfg[0];
    first_b     = 0;
    sb          = 0;
    k           = 0;
    gi          = 0;
    vi          = 0;
    t           = 0;
    base        = 0;

    // Zero-current check
    for (int s = 0; s < NUM_SUB; s++) begin
      for (int v = 0; v < NV_IN; v++) begin
        if (stim_voice_input[s][v] != '0) begin
          zero_cur = 1'b0; // RULE_18
        end
      end
    end
    link_ok = link_up & zero_cur; // RULE_18

    // Fault detection
    i_fault = safe_en & (current_sense > st.ilim); // RULE_10
    for (int b = 0; b < NUM_BOARDS; b++) begin
      for (int j = 0; j < 4; j++) begin
        if (safe_en && ({1'b0, compliance_mv[b][j]} > vlim)) begin
          v_fault = 1'b1; // RULE_14
        end
      end
    end

    // Arm source selection
    arm_req = remote ? touch_arm : host_arm; // RULE_13

    // Arming controller
    case (st.arm)
      svr_pkg::SVR_NOT_READY: begin
        if (link_ok) begin
          next_st.arm = svr_pkg::SVR_READY; // RULE_19
        end
      end
      svr_pkg::SVR_READY: begin
        if (!link_ok) begin
          next_st.arm = svr_pkg::SVR_NOT_READY;
        end else if (arm_req) begin
          next_st.arm = svr_pkg::SVR_ARMED; // RULE_17
        end
      end
      svr_pkg::SVR_ARMED: begin
        if (v_fault || i_fault || !link_up) begin
          next_st.arm = svr_pkg::SVR_NOT_READY; // RULE_10 RULE_14 RULE_19
        end else if (host_disarm) begin
          next_st.arm = svr_pkg::SVR_NOT_READY; // RULE_17
        end
      end
      default: begin
        next_st.arm = svr_pkg::SVR_NOT_READY;
      end
    endcase
    gate = ~safe_en | (st.arm == svr_pkg::SVR_ARMED); // RULE_11

    // Voice routing per board
    for (int b = 0; b < NUM_BOARDS; b++) begin
      used    = 1'b0;
      sb      = 0;
      k       = 0;
      first_b = 0;
      for (int s = 0; s < NUM_SUB; s++) begin
        if (!used && b >= first_b && b < first_b + int'(st.cfg[s].boards)) begin
          used = 1'b1; // RULE_03
          sb   = s;
          k    = b - first_b;
        end
        first_b = first_b + int'(st.cfg[s].boards);
      end
      c     = st.cfg[sb];
      shift = (c.dbl > 2'd2) ? 3'd2 : {1'b0, c.dbl}; // RULE_08
      next_st.gnd[b] = used ? c.ground : 2'b00; // RULE_15
      bmon[b]        = used ? c.monitor : 2'b00;
      next_st.red[b]   = (used && st.arm == svr_pkg::SVR_NOT_READY) ? 16'hFFFF : 16'h0000;
      next_st.green[b] = (used && st.arm == svr_pkg::SVR_READY) ? 16'hFFFF : 16'h0000; // RULE_12
      for (int j = 0; j < svr_pkg::HW_VOICES; j++) begin
        gi = j >> shift;
        case (c.mode)
          svr_pkg::SVR_MODE_NORMAL, svr_pkg::SVR_MODE_PARALLEL: begin
            vi = k * int'(c.vpb) + gi; // RULE_04 RULE_05 RULE_09
            ok = gi < int'(c.vpb);
          end
          svr_pkg::SVR_MODE_SERIAL: begin
            vi = 0; // RULE_06
            ok = gi == 0;
          end
          default: begin
            vi = gi; // RULE_07
            ok = gi < int'(c.vpb);
          end
        endcase
        amp = '0;
        t   = 0;
        if (ok && vi < NV_IN) begin
          amp = stim_voice_input[sb][vi]; // RULE_01
          t   = int'(stim_voice_input[sb][NV_IN + vi]);
        end
        base = (c.mode == svr_pkg::SVR_MODE_NORMAL) ? k * int'(c.range) : 0; // RULE_09
        if (c.mode == svr_pkg::SVR_MODE_SERIAL) begin
          in_rng = 1'b1;
          ch     = svr_pkg::SERIAL_CH; // RULE_06
        end else begin
          in_rng = (t > base) && (t <= base + int'(c.range));
          ch     = 4'(t - base - 1); // RULE_02
        end
        next_st.vout[b][j].en   = used & ok & in_rng & (amp != '0) & gate; // RULE_11
        next_st.vout[b][j].amp  = next_st.vout[b][j].en ? amp : '0;
        next_st.vout[b][j].chan = next_st.vout[b][j].en ? ch : 4'h0;
        if (next_st.vout[b][j].en && st.arm == svr_pkg::SVR_ARMED) begin
          next_st.green[b][ch] = 1'b1; // RULE_12
        end
      end
    end

    // Compliance monitor stream, one voice per cycle
    next_st.mon       = compliance_mv[st.mon_ptr[7:2]][st.mon_ptr[1:0]];
    next_st.mon_idx   = st.mon_ptr;
    next_st.mon_valid = bmon[st.mon_ptr[7:2]] != 2'b00; // RULE_16
    next_st.mon_store = bmon[st.mon_ptr[7:2]] == 2'b10; // RULE_16
    if (st.mon_ptr == 8'(NUM_BOARDS * 4 - 1)) begin
      next_st.mon_ptr = 8'h00;
    end else begin
      next_st.mon_ptr = st.mon_ptr + 8'h01;
    end

    // Register writes
    if (wr_commit) begin
      if (paddr == svr_pkg::ADDR_SAFE) begin
        next_st.safe = pwdata;
      end else if (paddr == svr_pkg::ADDR_ILIM) begin
        next_st.ilim = pwdata[15:0];
      end else if (paddr == svr_pkg::ADDR_IRQ_STAT) begin
        clr_irq = pwdata[svr_pkg::IRQ_W-1:0];
      end else if (paddr == svr_pkg::ADDR_IRQ_MASK) begin
        next_st.irq_mask = pwdata[svr_pkg::IRQ_W-1:0];
      end else begin
        for (int s = 0; s < NUM_SUB; s++) begin
          if (paddr == svr_pkg::ADDR_SUB_BASE + 12'(s) * svr_pkg::ADDR_SUB_STEP) begin
            next_st.cfg[s] = pwdata[18:0]; // RULE_03
          end
        end
      end
    end

    // Sticky interrupt status, set wins over clear
    set_irq[svr_pkg::IRQ_VFAULT]   = v_fault;
    set_irq[svr_pkg::IRQ_IFAULT]   = i_fault;
    set_irq[svr_pkg::IRQ_ARMED]    = (st.arm == svr_pkg::SVR_READY) &&
                                     (next_st.arm == svr_pkg::SVR_ARMED);
    set_irq[svr_pkg::IRQ_DISARMED] = (st.arm == svr_pkg::SVR_ARMED) &&
                                     (next_st.arm != svr_pkg::SVR_ARMED);
    next_st.irq_stat = (st.irq_stat & ~clr_irq) | set_irq;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);

    // Register reads
    if (paddr == svr_pkg::ADDR_CTRL) begin
      rdata = 32'h0000_0000;
    end else if (paddr == svr_pkg::ADDR_STATUS) begin
      rdata = {28'h000_0000, zero_cur, link_up, st.arm};
    end else if (paddr == svr_pkg::ADDR_SAFE) begin
      rdata = st.safe;
    end else if (paddr == svr_pkg::ADDR_ILIM) begin
      rdata = {16'h0000, st.ilim};
    end else if (paddr == svr_pkg::ADDR_IRQ_STAT) begin
      rdata = {28'h000_0000, st.irq_stat};
    end else if (paddr == svr_pkg::ADDR_IRQ_MASK) begin
      rdata = {28'h000_0000, st.irq_mask};
    end else begin
      rd_hit = 1'b0;
      for (int s = 0; s < NUM_SUB; s++) begin
        if (paddr == svr_pkg::ADDR_SUB_BASE + 12'(s) * svr_pkg::ADDR_SUB_STEP) begin
          rd_hit = 1'b1;
          rdata  = {13'h0000, st.cfg[s]};
        end
      end
    end

    // APB answer one cycle into the access phase
    next_st.pready  = acc & ~st.pready;
    next_st.prdata  = (acc && !st.pready && !pwrite) ? rdata : 32'h0000_0000;
    next_st.pslverr = acc & ~st.pready & ~rd_hit;
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st      <= '0;
      st.safe <= svr_pkg::SAFE_RST;
      st.ilim <= svr_pkg::ILIM_RST;
      st.arm  <= svr_pkg::SVR_NOT_READY;
      for (int s = 0; s < NUM_SUB; s++) begin
        st.cfg[s] <= svr_pkg::SUB_CFG_RST;
      end
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign prdata                 = st.prdata;
  assign pready                 = st.pready;
  assign pslverr                = st.pslverr;
  assign voice_out              = st.vout;
  assign led_red                = st.red;
  assign led_green              = st.green;
  assign ground_sel             = st.gnd;
  assign compliance_monitor_out = st.mon;
  assign mon_index              = st.mon_idx;
  assign mon_valid              = st.mon_valid;
  assign mon_store              = st.mon_store;
  assign arm_state              = st.arm;
  assign irq                    = st.irq;

endmodule // svr_top

// ===== common/svr_pkg.sv
// Constants and types of the voice router with arming control.
// Assumes one 25 MHz clock, synchronous active-high reset and an APB master.
// Overview of operation
// [RULE_01] Low words waveforms, high words target channels.
// [RULE_02] Four voices a board, each to any of 16 channels.
// [RULE_03] Isolated sub-stimulators, own config and input each.
// [RULE_04] Voice maps to board, hardware voice, channel range.
// [RULE_05] Parallel: boards wired together.
// [RULE_06] Serial: channel 16 shorted across boards.
// [RULE_07] Repeated: same voices on every board.
// [RULE_08] Doubling: voices single, paired or all joined.
// [RULE_09] Boards, voices and range per board set the mapping.
// [RULE_10] Safety on: overcurrent disarms.
// [RULE_11] Safety on: no output until armed.
// [RULE_12] LEDs: red not ready, green ready, active when armed.
// [RULE_13] Remote on: touchscreen arms; else host arms.
// [RULE_14] Safety on: voltage past max plus 1 V disarms.
// [RULE_15] Ground: per bank, first bank, or external jack.
// [RULE_16] Monitor: off, view, or view and store.
// [RULE_17] Not ready, ready, armed; arm from ready, disarm from armed.
// [RULE_18] Arming needs link up and zero current.
// [RULE_19] After fault: not ready until link and zero current.

package svr_pkg;

  localparam int unsigned DW = 16;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_SAFE     = 12'h008;
  localparam logic [11:0] ADDR_ILIM     = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
  localparam logic [11:0] ADDR_SUB_BASE = 12'h020;
  localparam logic [11:0] ADDR_SUB_STEP = 12'h004;

  // Field positions and IRQ width
  localparam int unsigned CTRL_ARM_BIT    = 0;
  localparam int unsigned CTRL_DISARM_BIT = 1;
  localparam int unsigned SAFE_EN_BIT     = 0;
  localparam int unsigned SAFE_REMOTE_BIT = 1;
  localparam int unsigned SAFE_VMAX_LSB   = 16;
  localparam int unsigned IRQ_W           = 4;
  localparam int unsigned IRQ_VFAULT      = 0;
  localparam int unsigned IRQ_IFAULT      = 1;
  localparam int unsigned IRQ_ARMED       = 2;
  localparam int unsigned IRQ_DISARMED    = 3;

  // Values after reset and voltage margin
  localparam logic [31:0] SAFE_RST     = 32'h01F4_0001;
  localparam logic [15:0] ILIM_RST     = 16'hFFFF;
  localparam logic [18:0] SUB_CFG_RST  = 19'h0_4210;
  localparam logic [15:0] VOLT_MARGIN_MV = 16'h03E8;

  // Counts and serial channel
  localparam int unsigned HW_VOICES = 4;
  localparam int unsigned CHANNELS  = 16;
  localparam logic [3:0]  SERIAL_CH = 4'hF;

  typedef enum logic [1:0] {
    SVR_NOT_READY = 2'b00,
    SVR_READY     = 2'b01,
    SVR_ARMED     = 2'b10
  } svr_arm_t;

  typedef enum logic [1:0] {
    SVR_MODE_NORMAL   = 2'b00,
    SVR_MODE_PARALLEL = 2'b01,
    SVR_MODE_SERIAL   = 2'b10,
    SVR_MODE_REPEATED = 2'b11
  } svr_mode_t;

  typedef struct packed {
    logic [1:0] monitor;
    logic [1:0] ground;
    logic [4:0] range;
    logic [2:0] vpb;
    logic [2:0] boards;
    logic [1:0] dbl;
    svr_mode_t  mode;
  } svr_sub_cfg_t;

  typedef struct packed {
    logic          en;
    logic [3:0]    chan;
    logic [DW-1:0] amp;
  } svr_voice_t;

endpackage

// ===== test/svr_assertions.sv
// Concurrent checks of arming states, LED levels and APB wait timing.
// Assumes binding into svr_top with board 0 owned by sub-stimulator 0.
`timescale 1ns/1ps

module svr_assertions #(
  parameter int unsigned NUM_BOARDS = 4
) (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       srst,
  // APB handshake
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pready,
  // Arming and LEDs
  input wire logic                       link_up,
  input wire svr_pkg::svr_arm_t          arm_state,
  input wire logic [NUM_BOARDS-1:0][15:0] led_red,
  input wire logic [NUM_BOARDS-1:0][15:0] led_green
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_to_armed;
    arm_state == svr_pkg::SVR_READY ##1 arm_state == svr_pkg::SVR_ARMED;
  endsequence

  property p_apb_wait;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  property p_legal_state;
    arm_state != 2'b11;
  endproperty
  property p_arm_from_ready;
    arm_state == svr_pkg::SVR_ARMED |-> $past(arm_state) != svr_pkg::SVR_NOT_READY;
  endproperty
  property p_arm_entry;
    s_to_armed |=> led_red[0] == 16'h0000;
  endproperty
  property p_led_not_ready;
    arm_state == svr_pkg::SVR_NOT_READY |=> led_red[0] == 16'hFFFF && led_green[0] == 16'h0000;
  endproperty
  property p_led_ready;
    arm_state == svr_pkg::SVR_READY |=> led_green[0] == 16'hFFFF && led_red[0] == 16'h0000;
  endproperty
  property p_ready_needs_link;
    arm_state == svr_pkg::SVR_READY |-> $past(link_up);
  endproperty
  property p_link_loss;
    arm_state == svr_pkg::SVR_ARMED && !link_up |=> arm_state == svr_pkg::SVR_NOT_READY;
  endproperty
  property p_stay_not_ready;
    arm_state == svr_pkg::SVR_NOT_READY && !link_up |=> arm_state == svr_pkg::SVR_NOT_READY;
  endproperty

  ////////////////////////////////////////////////////////////////////////////
  a_apb_wait: assert property (p_apb_wait) else $error("pready not one wait state");
  a_legal_state: assert property (p_legal_state) else $error("illegal arm state");
  a_arm_from_ready: assert property (p_arm_from_ready) else $error("armed from not ready");
  a_arm_entry: assert property (p_arm_entry) else $error("red lit after arming");
  a_led_not_ready: assert property (p_led_not_ready) else $error("leds not red");
  a_led_ready: assert property (p_led_ready) else $error("leds not green");
  a_ready_needs_link: assert property (p_ready_needs_link) else $error("ready without link");
  a_link_loss: assert property (p_link_loss) else $error("armed after link loss");
  a_stay_not_ready: assert property (p_stay_not_ready) else $error("left not ready");
endmodule // svr_assertions

bind svr_top svr_assertions #(.NUM_BOARDS(NUM_BOARDS)) u_svr_assertions (
  .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pready(pready),
  .link_up(link_up), .arm_state(arm_state), .led_red(led_red), .led_green(led_green));

// ===== test/svr_src_model.sv
// Upstream stimulation source model: packs waveform and target words per voice.
// Assumes the bench changes its commands just after a rising edge of clk_sys.
`timescale 1ns/1ps

module svr_src_model #(
  parameter int unsigned NUM_SUB = 2,
  parameter int unsigned NV_IN   = 8
) (
  // Clock
  input  wire logic                                      clk_sys,
  // Commands from the bench
  input  wire logic                                      mute,
  input  wire logic [NUM_SUB-1:0][NV_IN-1:0][15:0]       amp,
  input  wire logic [NUM_SUB-1:0][NV_IN-1:0][15:0]       tgt,
  // Word set to the router
  output logic      [NUM_SUB-1:0][2*NV_IN-1:0][15:0]     stim_voice_input
);
  initial stim_voice_input = '0;
  always @(posedge clk_sys) begin
    for (int s = 0; s < NUM_SUB; s++) begin
      for (int v = 0; v < NV_IN; v++) begin
        stim_voice_input[s][v] <= mute ? 16'h0000 : amp[s][v];
        stim_voice_input[s][NV_IN+v] <= tgt[s][v];
      end
    end
  end
endmodule // svr_src_model

// ===== test/tb_svr_top.sv
// Self-checking bench of the voice router: APB master, source model, scenarios.
// Assumes svr_top defaults and the checker bound to it.
`timescale 1ns/1ps

module tb_svr_top;
  logic                           clk_sys, srst, psel, penable, pwrite, pready, pslverr, irq;
  logic                           link_up, touch_arm, mute, err, mon_valid, mon_store;
  logic [11:0]                    paddr;
  logic [31:0]                    pwdata, prdata, rd;
  logic [1:0][7:0][15:0]          amp, tgt;
  logic [1:0][15:0][15:0]         svi;
  logic [15:0]                    current_sense, mon_out;
  logic [3:0][3:0][15:0]          comp;
  svr_pkg::svr_voice_t [3:0][3:0] vo;
  logic [3:0][15:0]               led_r, led_g;
  logic [3:0][1:0]                gsel;
  logic [7:0]                     mon_idx;
  svr_pkg::svr_arm_t              arm_state;
  int                             fail_count, cmp_count;
  localparam svr_pkg::svr_arm_t   NRD = svr_pkg::SVR_NOT_READY;
  localparam svr_pkg::svr_arm_t   RDY = svr_pkg::SVR_READY;
  localparam svr_pkg::svr_arm_t   ARM = svr_pkg::SVR_ARMED;

  svr_src_model src (.clk_sys(clk_sys), .mute(mute), .amp(amp), .tgt(tgt),
    .stim_voice_input(svi));
  svr_top dut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stim_voice_input(svi), .link_up(link_up), .touch_arm(touch_arm),
    .current_sense(current_sense), .compliance_mv(comp), .voice_out(vo), .led_red(led_r),
    .led_green(led_g), .ground_sel(gsel), .compliance_monitor_out(mon_out),
    .mon_index(mon_idx), .mon_valid(mon_valid), .mon_store(mon_store),
    .arm_state(arm_state), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk_sys);
    if (n >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask
  task automatic wait_chk(input svr_pkg::svr_arm_t e);
    for (int n = 0; n < 20 && arm_state !== e; n++) @(posedge clk_sys);
    chk("state", arm_state, e);
  endtask
  task automatic ctrl(input logic [31:0] d);
    apb(1'b1, svr_pkg::ADDR_CTRL, d);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] md, input logic [1:0] dbl,
                                      input logic [2:0] nb);
    cfg = {13'h0000, 4'h0, 5'd16, 3'd4, nb, dbl, md};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rchk("safe", svr_pkg::ADDR_SAFE, svr_pkg::SAFE_RST);
    rchk("ilim", svr_pkg::ADDR_ILIM, {16'h0000, svr_pkg::ILIM_RST});
    rchk("subcfg1", svr_pkg::ADDR_SUB_BASE + 12'h004, {13'h0000, svr_pkg::SUB_CFG_RST});
    rchk("irq_mask", svr_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk("unmapped err", err, 1'b1);
  endtask
  task automatic t_gate;
    link_up <= 1'b1;
    amp[0][0] <= 16'h0005;
    tgt[0][0] <= 16'h0001;
    hold(4);
    chk("state", arm_state, NRD);
    chk("gated", vo[0][0], 32'h0000_0000);
    chk("red", led_r[0], 16'hFFFF);
    ctrl(32'h0000_0001);
    hold(2);
    chk("state", arm_state, NRD);
  endtask
  task automatic t_arm;
    mute <= 1'b1;
    wait_chk(RDY);
    hold(1);
    chk("green", led_g[0], 16'hFFFF);
    ctrl(32'h0000_0002);
    chk("state", arm_state, RDY);
    apb(1'b1, svr_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
    ctrl(32'h0000_0001);
    wait_chk(ARM);
    hold(1);
    chk("irq", irq, 1'b1);
    rchk("irq_stat", svr_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
    apb(1'b1, svr_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
    rchk("irq_stat", svr_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    chk("irq", irq, 1'b0);
    mute <= 1'b0;
    tgt[0][0] <= 16'h0003;
    hold(3);
    chk("voice", vo[0][0], 32'h0012_0005);
    chk("led", led_g[0], 16'h0004);
    tgt[0][0] <= 16'h0011;
    hold(3);
    chk("range", vo[0][0].en, 1'b0);
  endtask
  task automatic t_fault;
    comp[0][1] <= 16'd1500;
    hold(4);
    chk("state", arm_state, ARM);
    comp[0][1] <= 16'd1501;
    wait_chk(NRD);
    comp[0][1] <= 16'd0;
    rchk("irq_stat", svr_pkg::ADDR_IRQ_STAT, 32'h0000_0009);
    hold(4);
    chk("state", arm_state, NRD);
    mute <= 1'b1;
    wait_chk(RDY);
    apb(1'b1, svr_pkg::ADDR_ILIM, 32'h0000_0064);
    current_sense <= 16'h0064;
    ctrl(32'h0000_0001);
    wait_chk(ARM);
    hold(2);
    chk("state", arm_state, ARM);
    current_sense <= 16'h0065;
    wait_chk(NRD);
    current_sense <= 16'h0000;
  endtask
  task automatic t_remote;
    apb(1'b1, svr_pkg::ADDR_SAFE, 32'h01F4_0003);
    wait_chk(RDY);
    ctrl(32'h0000_0001);
    hold(2);
    chk("state", arm_state, RDY);
    touch_arm <= 1'b1;
    hold(1);
    touch_arm <= 1'b0;
    wait_chk(ARM);
    ctrl(32'h0000_0002);
    wait_chk(NRD);
    wait_chk(RDY);
    touch_arm <= 1'b1;
    hold(1);
    touch_arm <= 1'b0;
    wait_chk(ARM);
    link_up <= 1'b0;
    wait_chk(NRD);
    link_up <= 1'b1;
  endtask
  task automatic route(input logic [31:0] c, input int vi, input logic [15:0] t,
                       input int b, input int j, input logic [3:0] ch);
    tgt[0][vi] <= t;
    apb(1'b1, svr_pkg::ADDR_SUB_BASE, c);
    hold(3);
    chk("voice_out", vo[b][j], {11'h000, 1'b1, ch, amp[0][vi]});
  endtask
  task automatic t_modes;
    apb(1'b1, svr_pkg::ADDR_SAFE, 32'h0000_0000);
    mute <= 1'b0;
    for (int v = 0; v < 8; v++) amp[0][v] <= 16'(v + 1);
    route(cfg(2'd0, 2'd0, 3'd1), 2, 16'd16, 0, 2, 4'hF);
    route(cfg(2'd0, 2'd0, 3'd2), 4, 16'd20, 1, 0, 4'h3);
    route(cfg(2'd1, 2'd0, 3'd2), 4, 16'd5, 1, 0, 4'h4);
    route(cfg(2'd3, 2'd0, 3'd2), 0, 16'd7, 1, 0, 4'h6);
    route(cfg(2'd2, 2'd0, 3'd2), 0, 16'd1, 1, 0, 4'hF);
    route(cfg(2'd0, 2'd1, 3'd1), 0, 16'd9, 0, 1, 4'h8);
    route(cfg(2'd0, 2'd2, 3'd1), 0, 16'd9, 0, 3, 4'h8);
  endtask
  task automatic t_ground_mon;
    int n;
    apb(1'b1, svr_pkg::ADDR_SUB_BASE, cfg(2'd0, 2'd0, 3'd1) | 32'h0005_0000);
    apb(1'b1, svr_pkg::ADDR_SUB_BASE + 12'h004, cfg(2'd0, 2'd0, 3'd1) | 32'h0000_8000);
    comp[0][2] <= 16'h0123;
    hold(3);
    chk("ground0", gsel[0], 2'd2);
    chk("ground1", gsel[1], 2'd1);
    for (n = 0; n < 40 && mon_idx !== 8'h02; n++) @(posedge clk_sys);
    chk("mon", {mon_valid, mon_store, mon_out}, {2'b11, 16'h0123});
    for (n = 0; n < 40 && mon_idx !== 8'h04; n++) @(posedge clk_sys);
    chk("mon off", mon_valid, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
  initial begin
    {srst, psel, penable, pwrite, link_up, touch_arm, mute} = 7'b1000000;
    {paddr, pwdata, current_sense} = '0;
    {amp, tgt, comp} = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs();
    t_gate();
    t_arm();
    t_fault();
    t_remote();
    t_modes();
    t_ground_mon();
    wrap_up();
  end
endmodule // tb_svr_top
